/* File: rtl/mcr_code_dma.sv */
// Purpose: Code-read DMA control, APB registers and guest code writer
// Assumes: DMA source streams DWORDs in pointer order on valid/ready
// Notes: Guest wait strobe is asynchronous and synchronised here
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
module mcr_code_dma #(
	parameter int FIFO_DEPTH = 8,
	parameter int FIFO_AW = 3
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Host memory read stream
	output logic o_dma_burst_req,
	output logic [31:0] o_dma_addr,
	input wire logic i_dma_valid,
	input wire logic [31:0] i_dma_data,
	output logic o_dma_ready,
	// Peripheral local bus code write
	output logic o_gb_cycle,
	output logic [2:0] o_gb_device_sel,
	output logic [2:0] o_gb_reg_sel,
	output logic [31:0] o_gb_data,
	input wire logic i_peripheral_wait_strobe_n,
	// Status levels
	output logic o_report_step_irq,
	output logic o_code_write_timeout
);
	typedef enum logic [0:0] {GB_IDLE, GB_WRITE} mcr_gb_state_type;

	localparam int LVL_W = FIFO_AW + 1;
	localparam logic [6:0] TO_CNT = 7'(mcr_pkg::TIMEOUT_CYC);
	localparam logic [6:0] MIN_CNT = 7'(mcr_pkg::GB_MIN_CYC);

	// Size code to DWORD count, with unsupported codes mapped to default
	function automatic logic [mcr_pkg::PTR_W-1:0] code_dwords(input logic [2:0] c);
		logic [2:0] e;
		e = (c > mcr_pkg::SIZE_MAX_CODE) ? mcr_pkg::RST_SIZE : c;
		code_dwords = mcr_pkg::DWORDS_8KB << e;
	endfunction

	mcr_fifo_if #(.LVL_W(LVL_W)) fif ();

	mcr_code_fifo #(
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.f(fif.mem)
	);

	// Registers
	logic [31:0] base_r;
	logic timeout_r;
	logic flush_r;
	logic [2:0] dev_r;
	logic [2:0] reg_r;
	logic [2:0] size_r;
	logic [2:0] step_r;
	logic rden_r;
	logic [2:0] thr_r;
	logic auto_r;
	logic repirq_r;
	logic [mcr_pkg::PTR_W-1:0] ptr_r;
	logic [31:0] addr_r;

	// Guest writer state
	mcr_gb_state_type gb_state_r;
	logic [6:0] gb_cnt_r;
	logic [31:0] gb_data_r;
	logic ws_s1_r;
	logic ws_s2_r;
	logic ws_s3_r;
	logic ws_r;

	// APB decode
	logic wr_en;
	logic hit_base;
	logic hit_ctrl;
	logic hit_ptr;
	logic hit_irq;
	logic mapped;

	assign hit_base = (i_paddr == mcr_pkg::ADDR_BASE);
	assign hit_ctrl = (i_paddr == mcr_pkg::ADDR_CTRL);
	assign hit_ptr = (i_paddr == mcr_pkg::ADDR_PTR);
	assign hit_irq = (i_paddr == mcr_pkg::ADDR_IRQ);
	assign mapped = hit_base | hit_ctrl | hit_ptr | hit_irq;
	assign wr_en = i_psel & i_penable & i_pwrite & mapped;
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~mapped;

	// DMA stream control
	logic [mcr_pkg::PTR_W-1:0] size_dw;
	logic [mcr_pkg::PTR_W-1:0] step_dw;
	logic [mcr_pkg::PTR_W-1:0] ptr_inc;
	logic in_range;
	logic accept;
	logic below_thr;
	logic step_cross;
	logic to_event;

	assign size_dw = code_dwords(size_r);
	assign step_dw = code_dwords(step_r);
	assign ptr_inc = ptr_r + mcr_pkg::PTR_W'(1);
	assign in_range = auto_r | (ptr_r < size_dw);
	assign below_thr = (fif.level < LVL_W'(thr_r));
	assign o_dma_ready = rden_r & ~flush_r & in_range & ~fif.full;
	assign o_dma_burst_req = rden_r & ~flush_r & in_range & below_thr;
	assign accept = i_dma_valid & o_dma_ready;
	assign step_cross = accept && ((ptr_inc & (step_dw - mcr_pkg::PTR_W'(1))) == '0);

	assign fif.push = accept;
	assign fif.push_data = i_dma_data;
	assign fif.flush = flush_r;

	// Base address
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			base_r <= mcr_pkg::BASE_RST;
		end else if (wr_en && hit_base) begin
			base_r <= {i_pwdata[31:2], 2'b00};
		end
	end

	// Control fields
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			flush_r <= mcr_pkg::RST_FLUSH;
			dev_r <= mcr_pkg::RST_DEV;
			reg_r <= mcr_pkg::RST_REG;
			size_r <= mcr_pkg::RST_SIZE;
			step_r <= mcr_pkg::RST_STEP;
			rden_r <= 1'b0;
			thr_r <= mcr_pkg::RST_THR;
			auto_r <= 1'b0;
		end else if (wr_en && hit_ctrl) begin
			flush_r <= i_pwdata[mcr_pkg::B_FLUSH];
			dev_r <= i_pwdata[mcr_pkg::B_DEV_LO +: 3];
			reg_r <= i_pwdata[mcr_pkg::B_REG_LO +: 3];
			size_r <= i_pwdata[mcr_pkg::B_SIZE_LO +: 3];
			step_r <= i_pwdata[mcr_pkg::B_STEP_LO +: 3];
			rden_r <= i_pwdata[mcr_pkg::B_RDEN];
			thr_r <= i_pwdata[mcr_pkg::B_THR_LO +: 3];
			auto_r <= i_pwdata[mcr_pkg::B_AUTO];
		end
	end

	// Sticky status flag: a hardware set wins over a host write-one clear
	function automatic logic sticky_next(input logic q, input logic set, input logic clr);
		logic n;
		n = q;
		if (clr) begin
			n = 1'b0;
		end
		if (set) begin
			n = 1'b1;
		end
		return n;
	endfunction

	logic clr_timeout;
	logic clr_repirq;
	logic ptr_wrap;

	assign clr_timeout = wr_en && hit_ctrl && i_pwdata[mcr_pkg::B_TIMEOUT];
	assign clr_repirq = wr_en && hit_irq && i_pwdata[mcr_pkg::B_REPIRQ];
	assign ptr_wrap = auto_r && (ptr_inc >= size_dw);

	// Write timeout flag
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			timeout_r <= 1'b0;
		end else begin
			timeout_r <= sticky_next(timeout_r, to_event, clr_timeout);
		end
	end

	// Report step status
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			repirq_r <= 1'b0;
		end else begin
			repirq_r <= sticky_next(repirq_r, step_cross, clr_repirq);
		end
	end

	// DWORD pointer
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ptr_r <= '0;
		end else if (accept) begin
			if (ptr_wrap) begin
				ptr_r <= '0;
			end else begin
				ptr_r <= ptr_inc;
			end
		end else if (wr_en && hit_ptr && !rden_r) begin
			ptr_r <= {1'b0, i_pwdata[15:0]};
		end
	end

	// Host address of the next DWORD
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			addr_r <= '0;
		end else begin
			addr_r <= base_r + {13'h0000, ptr_r, 2'b00};
		end
	end
	assign o_dma_addr = addr_r;

	// Control register image; reserved bits stay zero
	function automatic logic [31:0] ctrl_image();
		logic [31:0] v;
		v = '0;
		v[mcr_pkg::B_TIMEOUT] = timeout_r;
		v[mcr_pkg::B_EMPTY] = fif.empty;
		v[mcr_pkg::B_FLUSH] = flush_r;
		v[mcr_pkg::B_DEV_LO +: 3] = dev_r;
		v[mcr_pkg::B_REG_LO +: 3] = reg_r;
		v[mcr_pkg::B_SIZE_LO +: 3] = size_r;
		v[mcr_pkg::B_STEP_LO +: 3] = step_r;
		v[mcr_pkg::B_RDEN] = rden_r;
		v[mcr_pkg::B_THR_LO +: 3] = thr_r;
		v[mcr_pkg::B_AUTO] = auto_r;
		return v;
	endfunction

	// Readback word for an address; unmapped addresses read zero
	function automatic logic [31:0] read_word(input logic [11:0] a);
		logic [31:0] v;
		v = '0;
		case (a)
			mcr_pkg::ADDR_BASE: begin
				v = base_r;
			end
			mcr_pkg::ADDR_CTRL: begin
				v = ctrl_image();
			end
			mcr_pkg::ADDR_PTR: begin
				v[15:0] = ptr_r[15:0];
			end
			mcr_pkg::ADDR_IRQ: begin
				v[mcr_pkg::B_REPIRQ] = repirq_r;
			end
			default: begin
				v = '0;
			end
		endcase
		return v;
	endfunction

	// Read data is loaded in the setup cycle and stands through the access
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_prdata <= '0;
		end else if (i_psel && !i_penable && !i_pwrite) begin
			o_prdata <= read_word(i_paddr);
		end
	end

	// Wait strobe synchroniser chain, idle level high
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ws_s1_r <= 1'b1;
			ws_s2_r <= 1'b1;
			ws_s3_r <= 1'b1;
		end else begin
			ws_s1_r <= i_peripheral_wait_strobe_n;
			ws_s2_r <= ws_s1_r;
			ws_s3_r <= ws_s2_r;
		end
	end

	// A change counts once stages two and three agree
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ws_r <= 1'b1;
		end else if (ws_s2_r == ws_s3_r) begin
			ws_r <= ws_s3_r;
		end
	end

	// Guest code write cycle
	logic gb_start;
	logic gb_done;

	assign gb_start = (gb_state_r == GB_IDLE) && !fif.empty && !flush_r;
	assign gb_done = (gb_cnt_r >= MIN_CNT) && ws_r;
	assign to_event = (gb_state_r == GB_WRITE) && !gb_done && (gb_cnt_r == TO_CNT);
	assign fif.pop = gb_start;

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			gb_state_r <= GB_IDLE;
		end else begin
			unique case (gb_state_r)
				GB_IDLE: begin
					if (gb_start) begin
						gb_state_r <= GB_WRITE;
					end
				end
				GB_WRITE: begin
					if (gb_done || to_event) begin
						gb_state_r <= GB_IDLE;
					end
				end
			endcase
		end
	end

	// Cycle length counter, zero while idle
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			gb_cnt_r <= '0;
		end else if (gb_state_r == GB_WRITE) begin
			gb_cnt_r <= gb_cnt_r + 7'h01;
		end else begin
			gb_cnt_r <= '0;
		end
	end

	// Code word held for the whole cycle
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			gb_data_r <= '0;
		end else if (gb_start) begin
			gb_data_r <= fif.pop_data;
		end
	end

	assign o_gb_cycle = (gb_state_r == GB_WRITE);
	assign o_gb_data = gb_data_r;
	assign o_gb_device_sel = dev_r;
	assign o_gb_reg_sel = reg_r;
	assign o_report_step_irq = repirq_r;
	assign o_code_write_timeout = timeout_r;
endmodule

/* File: rtl/mcr_code_fifo.sv */
// Purpose: Internal code FIFO of DWORDs
// Assumes: Push only when not full, pop only when not empty
// Notes: Flush holds the FIFO empty
`timescale 1ns/100ps
module mcr_code_fifo #(
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// Control side
	mcr_fifo_if.mem f
);
	logic [31:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;

	always_ff @(posedge i_core_clk) begin
		if (f.push && !f.flush) begin
			mem_r[wr_r] <= f.push_data;
		end
	end

	// Flush discards everything held
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else if (f.flush) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (f.push) begin
				wr_r <= wr_r + AW'(1);
			end
			if (f.pop) begin
				rd_r <= rd_r + AW'(1);
			end
			if (f.push && !f.pop) begin
				cnt_r <= cnt_r + (AW+1)'(1);
			end else if (f.pop && !f.push) begin
				cnt_r <= cnt_r - (AW+1)'(1);
			end
		end
	end

	assign f.pop_data = mem_r[rd_r];
	assign f.level = cnt_r;
	assign f.empty = (cnt_r == '0);
	assign f.full = (cnt_r == (AW+1)'(DEPTH));
endmodule

/* File: rtl/mcr_fifo_if.sv */
// Purpose: Connection between control logic and code FIFO
// Assumes: Single clock domain
// Notes: Level counts DWORDs held
`timescale 1ns/100ps
interface mcr_fifo_if #(parameter int LVL_W = 4);
	logic push;
	logic [31:0] push_data;
	logic pop;
	logic [31:0] pop_data;
	logic flush;
	logic [LVL_W-1:0] level;
	logic empty;
	logic full;
	modport ctl (output push, push_data, pop, flush, input pop_data, level, empty, full);
	modport mem (input push, push_data, pop, flush, output pop_data, level, empty, full);
endinterface

/* File: rtl/mcr_pkg.sv */
// Purpose: Constants for the code-read DMA control block
// Assumes: APB register access, single clock domain
// Notes: Functional notes follow
// Functional notes
// - Set timeout flag when a guest code write lasts over 64 clocks.
// - Writing one clears timeout flag; a simultaneous set wins.
// - FIFO empty flag reads one when buffer empty; one after reset.
// - Flush bit discards buffered code; buffer empty after; resets to one.
// - Three-bit device select picks the guest for code writes; resets zero.
// - Three-bit register select picks guest register written; resets zero.
// - Buffer size field encodes 8 KB to 256 KB; resets to 011b.
// - Size codes 110b and 111b act as the 64 KB default.
// - Report step raises interrupt per 8..256 KB transferred; resets 001b.
// - Read enable clear halts transfers, pointer kept; set resumes; resets zero.
// - Enabled and fill below threshold requests a burst; threshold resets 6.
// - Auto wrap clear stops transfers at buffer end; resets zero.
// - Auto wrap set restarts pointer at buffer start, reading cyclically.
// - Reserved control bits read zero and ignore writes.
// - Pointer counts DWORDs from base; writable only while reading disabled.
// - Report status bit sets whenever pointer crosses a step boundary.
// - Base address is DWORD aligned, low two bits fixed zero.
package mcr_pkg;
	localparam logic [11:0] ADDR_BASE = 12'h030;
	localparam logic [11:0] ADDR_CTRL = 12'h034;
	localparam logic [11:0] ADDR_PTR = 12'h038;
	localparam logic [11:0] ADDR_IRQ = 12'h03C;
	localparam int B_TIMEOUT = 30;
	localparam int B_EMPTY = 29;
	localparam int B_FLUSH = 28;
	localparam int B_DEV_LO = 20;
	localparam int B_REG_LO = 16;
	localparam int B_SIZE_LO = 12;
	localparam int B_STEP_LO = 8;
	localparam int B_RDEN = 7;
	localparam int B_THR_LO = 1;
	localparam int B_AUTO = 0;
	localparam int B_REPIRQ = 28;
	localparam logic [31:0] BASE_RST = 32'h0FFF_FFFC;
	localparam logic RST_FLUSH = 1'b1;
	localparam logic [2:0] RST_DEV = 3'h0;
	localparam logic [2:0] RST_REG = 3'h0;
	localparam logic [2:0] RST_SIZE = 3'h3;
	localparam logic [2:0] RST_STEP = 3'h1;
	localparam logic [2:0] RST_THR = 3'h6;
	localparam logic [2:0] SIZE_MAX_CODE = 3'h5;
	localparam logic [16:0] DWORDS_8KB = 17'h00800;
	localparam int TIMEOUT_CYC = 64;
	localparam int GB_MIN_CYC = 4;
	localparam int PTR_W = 17;
endpackage

/* File: verif/mcr_code_dma_sva.sv */
// Purpose: Port checks for code DMA control
// Assumes: One clock domain
// Notes: Bound to mcr_code_dma
`timescale 1ns/100ps
module mcr_code_dma_sva (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// APB
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// Stream and guest
	input wire logic o_dma_burst_req,
	input wire logic o_dma_ready,
	input wire logic o_gb_cycle,
	input wire logic o_report_step_irq,
	input wire logic o_code_write_timeout
);
	logic [6:0] cnt_r;
	logic acc;
	logic unmap;
	logic clr_t;
	logic clr_i;
	assign acc = i_psel && i_penable;
	assign unmap = !(i_paddr inside {mcr_pkg::ADDR_BASE, mcr_pkg::ADDR_CTRL,
		mcr_pkg::ADDR_PTR, mcr_pkg::ADDR_IRQ});
	assign clr_t = acc && i_pwrite && i_paddr == mcr_pkg::ADDR_CTRL && i_pwdata[30];
	assign clr_i = acc && i_pwrite && i_paddr == mcr_pkg::ADDR_IRQ && i_pwdata[28];
	// Cycles the current guest write has been open
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			cnt_r <= 7'h00;
		else if (!o_gb_cycle)
			cnt_r <= 7'h00;
		else if (cnt_r != 7'h7F)
			cnt_r <= cnt_r + 7'h01;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	sequence long_s;
		o_gb_cycle && cnt_r == 7'h40;
	endsequence
	AST_PREADY: assert property (o_pready) else $error("pready low");
	AST_SLVERR: assert property (acc && unmap |-> o_pslverr && (i_pwrite || o_prdata == 32'h0))
		else $error("unmapped access not refused");
	AST_TOUT_SET: assert property (long_s |=> o_code_write_timeout && !o_gb_cycle)
		else $error("long guest write not timed out");
	AST_TOUT_CAUSE: assert property ($rose(o_code_write_timeout) |->
		$past(o_gb_cycle) && $past(cnt_r) == 7'h40) else $error("timeout without cause");
	AST_GB_MAX: assert property (o_gb_cycle |-> cnt_r <= 7'h40)
		else $error("guest write too long");
	AST_TOUT_HOLD: assert property (o_code_write_timeout && !clr_t |=> o_code_write_timeout)
		else $error("timeout flag lost");
	AST_IRQ_HOLD: assert property (o_report_step_irq && !clr_i |=> o_report_step_irq)
		else $error("report flag lost");
	AST_BURST_READY: assert property (o_dma_burst_req |-> o_dma_ready)
		else $error("burst request while not ready");
endmodule
bind mcr_code_dma mcr_code_dma_sva u_sva (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_dma_burst_req(o_dma_burst_req), .o_dma_ready(o_dma_ready), .o_gb_cycle(o_gb_cycle),
	.o_report_step_irq(o_report_step_irq), .o_code_write_timeout(o_code_write_timeout));

/* File: verif/mcr_guest_model.sv */
// Purpose: Guest device on the peripheral local bus
// Assumes: Wait strobe pulled low as the cycle starts
// Notes: i_hold_cyc zero answers at once
`timescale 1ns/100ps
module mcr_guest_model (
	// Clock
	input wire logic i_core_clk,
	// Guest bus
	input wire logic i_gb_cycle,
	input wire logic [31:0] i_gb_data,
	input wire logic [7:0] i_hold_cyc,
	output logic o_wait_strobe_n
);
	int cnt = 0;
	logic [31:0] got[$];
	assign o_wait_strobe_n = !(i_gb_cycle && cnt < i_hold_cyc);
	always @(posedge i_core_clk) begin
		cnt <= i_gb_cycle ? cnt + 1 : 0;
		if (i_gb_cycle && cnt == 0)
			got.push_back(i_gb_data);
	end
endmodule

/* File: verif/tb.sv */
// Purpose: Self-checking bench for code DMA control
// Assumes: APB master and host stream driven here
// Notes: Guest side is a separate model
`timescale 1ns/100ps
module tb;
	localparam logic [11:0] A_BS = mcr_pkg::ADDR_BASE;
	localparam logic [11:0] A_CT = mcr_pkg::ADDR_CTRL;
	localparam logic [11:0] A_PT = mcr_pkg::ADDR_PTR;
	localparam logic [11:0] A_IQ = mcr_pkg::ADDR_IRQ;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, dv = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0, dd = 32'h0, prd, rdv, w, daddr, gdata;
	logic pready, perr, breq, drdy, gcyc, wsn, irq, tout;
	logic [2:0] gdev, greg;
	logic [7:0] hold = 8'h00;
	logic [31:0] exq[$];
	int n_fail = 0, checks = 0, seed = 32'hbdea, i;
	mcr_code_dma uut (.i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready),
		.o_pslverr(perr), .o_dma_burst_req(breq), .o_dma_addr(daddr), .i_dma_valid(dv),
		.i_dma_data(dd), .o_dma_ready(drdy), .o_gb_cycle(gcyc), .o_gb_device_sel(gdev),
		.o_gb_reg_sel(greg), .o_gb_data(gdata), .i_peripheral_wait_strobe_n(wsn),
		.o_report_step_irq(irq), .o_code_write_timeout(tout));
	mcr_guest_model g (.i_core_clk(clk), .i_gb_cycle(gcyc), .i_gb_data(gdata),
		.i_hold_cyc(hold), .o_wait_strobe_n(wsn));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic report_and_stop;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		logic ok;
		psel <= 1'b1;
		pwr <= wr;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		ok = 1'b0;
		for (k = 0; k < 20 && !ok; k++) begin
			@(negedge clk);
			ok = pready;
			rdv = prd;
			@(posedge clk);
		end
		if (!ok) begin
			chk("pready", 32'h1, 32'h0);
			report_and_stop();
		end
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("prdata", e, rdv);
	endtask
	task automatic feed(input int n);
		int j, k;
		logic ok;
		for (j = 0; j < n; j++) begin
			dv <= 1'b1;
			dd <= $random(seed);
			ok = 1'b0;
			for (k = 0; k < 300 && !ok; k++) begin
				@(negedge clk);
				ok = drdy;
				@(posedge clk);
			end
			if (!ok) begin
				chk("dma_ready", 32'h1, 32'h0);
				report_and_stop();
			end
			exq.push_back(dd);
		end
		dv <= 1'b0;
		dd <= ~dd;
	endtask
	task automatic drain;
		int k;
		for (k = 0; k < 3000 && g.got.size() < exq.size(); k++)
			@(posedge clk);
		chk("gb_count", exq.size(), g.got.size());
		for (k = 0; k < exq.size(); k++)
			chk("gb_data", exq[k], g.got[k]);
		exq.delete();
		g.got.delete();
		repeat (8) @(posedge clk);
	endtask
	function automatic logic [31:0] ctl(input logic [2:0] sz, input logic au);
		return 32'h0052_008C | {17'h0, sz, 12'h000} | {31'h0, au};
	endfunction
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk(A_CT, 32'h3000_310C);
		rchk(A_BS, 32'h0FFF_FFFC);
		rchk(A_PT, 32'h0);
		rchk(12'h040, 32'h0);
		$display("test reset done");
		apb(1'b1, A_CT, 32'hFFFF_FFFF);
		rchk(A_CT, 32'h3077_778F);
		for (i = 0; i < 6; i++) begin
			w = $random(seed) & 32'hFFFF_FF7F;
			apb(1'b1, A_CT, w);
			rchk(A_CT, (w & 32'h1077_770F) | 32'h2000_0000);
			apb(1'b1, A_PT, w);
			rchk(A_PT, w & 32'hFFFF);
			apb(1'b1, A_BS, w);
			rchk(A_BS, w & 32'hFFFF_FFFC);
		end
		apb(1'b1, A_CT, 32'h1000_0080);
		apb(1'b1, A_PT, ~w);
		rchk(A_PT, w & 32'hFFFF);
		$display("test registers done");
		apb(1'b1, A_CT, 32'h1000_0000);
		apb(1'b1, A_BS, 32'h1000_0000);
		apb(1'b1, A_PT, 32'h3FFC);
		apb(1'b1, A_CT, ctl(3'h6, 1'b0));
		chk("burst", 32'h1, breq);
		chk("addr", 32'h1000_FFF0, daddr);
		feed(4);
		drain();
		chk("ready", 32'h0, drdy);
		chk("burst", 32'h0, breq);
		chk("irq", 32'h1, irq);
		chk("dev", 32'h5, gdev);
		chk("reg", 32'h2, greg);
		rchk(A_PT, 32'h4000);
		apb(1'b1, A_IQ, 32'h1000_0000);
		rchk(A_IQ, 32'h0);
		apb(1'b1, A_CT, 32'h0);
		apb(1'b1, A_PT, 32'h07FE);
		apb(1'b1, A_CT, ctl(3'h0, 1'b1));
		hold <= 8'h03;
		feed(2);
		drain();
		chk("addr", 32'h1000_0000, daddr);
		chk("ready", 32'h1, drdy);
		chk("irq", 32'h1, irq);
		$display("test stream done");
		hold <= 8'hC8;
		feed(4);
		rchk(A_CT, ctl(3'h0, 1'b1) & 32'hDFFF_FFFF);
		repeat (80) @(posedge clk);
		chk("timeout", 32'h1, tout);
		apb(1'b1, A_CT, 32'h1000_0080);
		chk("ready", 32'h0, drdy);
		chk("burst", 32'h0, breq);
		repeat (80) @(posedge clk);
		rchk(A_CT, 32'h7000_0080);
		apb(1'b1, A_CT, 32'h5000_0000);
		rchk(A_CT, 32'h3000_0000);
		exq.delete();
		g.got.delete();
		$display("test timeout done");
		report_and_stop();
	end
endmodule
